/* File: shared/ctw_defs.vh */
`ifndef CTW_DEFS_VH
`define CTW_DEFS_VH
// ----------------------------------------
// Segment layout
// ----------------------------------------
`define CTW_SEG_BASE      16'h10C0
`define CTW_FIRST_REC     16'h10C2
`define CTW_SEG_LAST      16'h10FF
`define CTW_SEG_END       16'h1100
`define CTW_HDR_BYTES     16'h0002
`define CTW_WORD_STEP     16'h0002
// ----------------------------------------
// Tag codes
// ----------------------------------------
`define CTW_TAG_EMPTY     8'hFE
`define CTW_TAG_OSC       8'h01
`define CTW_TAG_CONV      8'h08
// ----------------------------------------
// Oscillator record offsets (value field)
// ----------------------------------------
`define CTW_OSC_RNG_1M    4'h7
`define CTW_OSC_STP_1M    4'h6
`define CTW_OSC_RNG_8M    4'h5
`define CTW_OSC_STP_8M    4'h4
`define CTW_OSC_RNG_12M   4'h3
`define CTW_OSC_STP_12M   4'h2
`define CTW_OSC_RNG_16M   4'h1
`define CTW_OSC_STP_16M   4'h0
`define CTW_OSC_LEN       4'h8
// ----------------------------------------
// Converter record word offsets (value field)
// ----------------------------------------
`define CTW_CNV_GAIN      5'h00
`define CTW_CNV_OFFS      5'h02
`define CTW_CNV_LREF      5'h04
`define CTW_CNV_LT30      5'h06
`define CTW_CNV_LT85      5'h08
`define CTW_CNV_HREF      5'h0A
`define CTW_CNV_HT30      5'h0C
`define CTW_CNV_HT85      5'h0E
`define CTW_CNV_LEN       5'h10
// ----------------------------------------
// Frequency select codes
// ----------------------------------------
`define CTW_FSEL_1M       2'h0
`define CTW_FSEL_8M       2'h1
`define CTW_FSEL_12M      2'h2
`define CTW_FSEL_16M      2'h3
`endif

/* File: hdl/ctw_walker.v */
// Contract
// (R1) First segment word is the checksum; it covers 0x10C2 through 0x10FF.
// (R2) Check value is XOR of the 31 words after the checksum word.
// (R3) Valid only if XOR plus stored checksum is zero; else flag error.
// (R4) Record parsing starts at 0x10C2 reading a tag byte.
// (R5) Byte after tag is the value-field length in bytes.
// (R6) Next tag address is tag address plus two plus length.
// (R7) Walk stops when next tag address reaches segment end; the code stops at 0x10FF, the last segment byte.
// (R8) Tag 0xFE is filler: extract nothing, skip by length.
// (R9) Tag 0x01 marks the oscillator calibration record.
// (R10) Tag 0x08 marks the converter calibration record.
// (R11) Unknown tags are skipped by length without ending the walk.
// (R12) Oscillator bytes: 1 MHz at offsets 7/6, 8 MHz at 5/4.
// (R13) Oscillator bytes: 12 MHz at offsets 3/2, 16 MHz at 1/0.
// (R14) Apply: clear step register, write range, then write step.
// (R15) Oscillator bytes may be fetched at fixed absolute addresses.
// (R16) Converter words: gain 0, offset 2, low-reference scale 4.
// (R17) Converter words: low temps 6/8, high scale 10, high temps 12/14.
`timescale 1ns/10ps
`include "ctw_defs.vh"
module ctw_walker (
  // Clock and reset
  input  wire        clock_i,
  input  wire        sys_rst_i,
  // Control
  input  wire        start_i,
  input  wire [1:0]  freq_sel_i,
  input  wire        apply_en_i,
  input  wire        direct_osc_i,
  // Flash information memory read port
  output reg         mem_rd_o,
  output reg  [15:0] mem_addr_o,
  input  wire        mem_ack_i,
  input  wire [15:0] mem_data_i,
  // Clock-control register writes
  output reg         clk_wr_o,
  output reg         clk_sel_range_o,
  output reg  [7:0]  clk_wdata_o,
  // Status
  output reg         busy_o,
  output reg         done_o,
  output reg         seg_valid_o,
  output reg         chk_err_o,
  output reg         osc_found_o,
  output reg         conv_found_o,
  // Extracted calibration
  output reg  [7:0]  range_byte_o,
  output reg  [7:0]  step_byte_o,
  output reg  [15:0] gain_word_o,
  output reg  [15:0] offset_word_o,
  output reg  [15:0] low_reference_scale_word_o,
  output reg  [15:0] low_ref_temp30_result_o,
  output reg  [15:0] low_ref_temp85_result_o,
  output reg  [15:0] high_reference_scale_word_o,
  output reg  [15:0] high_ref_temp30_result_o,
  output reg  [15:0] high_ref_temp85_result_o
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_CHK  = 4'h1;
  localparam [3:0] ST_HDR  = 4'h2;
  localparam [3:0] ST_VAL  = 4'h3;
  localparam [3:0] ST_NEXT = 4'h4;
  localparam [3:0] ST_AP0  = 4'h5;
  localparam [3:0] ST_AP1  = 4'h6;
  localparam [3:0] ST_AP2  = 4'h7;
  localparam [3:0] ST_DONE = 4'h8;
  localparam [3:0] ST_DIR  = 4'h9;

  reg [3:0]  state_r;
  reg [15:0] addr_r;
  reg [15:0] xor_r;
  reg [15:0] csum_r;
  reg [15:0] tag_addr_r;
  reg [7:0]  tag_r;
  reg [7:0]  len_r;
  reg [7:0]  voff_r;

  // Offset of the range byte for the selected frequency
  function [3:0] rng_off;
    input [1:0] sel;
    begin
      case (sel)
        `CTW_FSEL_1M:  rng_off = `CTW_OSC_RNG_1M;  // R12
        `CTW_FSEL_8M:  rng_off = `CTW_OSC_RNG_8M;  // R12
        `CTW_FSEL_12M: rng_off = `CTW_OSC_RNG_12M; // R13
        default:       rng_off = `CTW_OSC_RNG_16M; // R13
      endcase
    end
  endfunction

  // Word address: tag header plus a value offset, word aligned
  function [15:0] val_addr;
    input [15:0] tag_a;
    input [7:0]  off;
    begin
      val_addr = tag_a + `CTW_HDR_BYTES + {8'h00, off};
    end
  endfunction

  // Pick a byte out of a word by address parity (low byte at even)
  function [7:0] pick_byte;
    input [15:0] w;
    input        odd;
    begin
      pick_byte = odd ? w[15:8] : w[7:0];
    end
  endfunction

  wire [3:0]  sel_rng_off = rng_off(freq_sel_i);
  wire [15:0] next_tag    = tag_addr_r + `CTW_HDR_BYTES + {8'h00, len_r}; // R6
  wire [15:0] osc_base    = `CTW_SEG_END - `CTW_HDR_BYTES - {12'h000, `CTW_OSC_LEN};

  // ----------------------------------------
  // Walker sequencer
  // ----------------------------------------
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r      <= ST_IDLE;
      addr_r       <= 16'h0000;
      xor_r        <= 16'h0000;
      csum_r       <= 16'h0000;
      tag_addr_r   <= 16'h0000;
      tag_r        <= 8'h00;
      len_r        <= 8'h00;
      voff_r       <= 8'h00;
      mem_rd_o     <= 1'b0;
      mem_addr_o   <= 16'h0000;
      clk_wr_o     <= 1'b0;
      clk_sel_range_o <= 1'b0;
      clk_wdata_o  <= 8'h00;
      busy_o       <= 1'b0;
      done_o       <= 1'b0;
      seg_valid_o  <= 1'b0;
      chk_err_o    <= 1'b0;
      osc_found_o  <= 1'b0;
      conv_found_o <= 1'b0;
      range_byte_o <= 8'h00;
      step_byte_o  <= 8'h00;
      gain_word_o  <= 16'h0000;
      offset_word_o <= 16'h0000;
      low_reference_scale_word_o  <= 16'h0000;
      low_ref_temp30_result_o     <= 16'h0000;
      low_ref_temp85_result_o     <= 16'h0000;
      high_reference_scale_word_o <= 16'h0000;
      high_ref_temp30_result_o    <= 16'h0000;
      high_ref_temp85_result_o    <= 16'h0000;
    end else begin
      done_o   <= 1'b0;
      clk_wr_o <= 1'b0;
      // Read strobe is one cycle; each read state waits for the acknowledge
      mem_rd_o <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start_i) begin
            busy_o      <= 1'b1;
            seg_valid_o <= 1'b0;
            chk_err_o   <= 1'b0;
            osc_found_o <= 1'b0;
            conv_found_o <= 1'b0;
            xor_r       <= 16'h0000;
            mem_rd_o    <= 1'b1;
            if (direct_osc_i) begin
              // Fixed location, no chain walk and no checksum
              state_r    <= ST_DIR; // R15
              mem_addr_o <= val_addr(osc_base, {4'h0, sel_rng_off & 4'hE});
            end else begin
              state_r    <= ST_CHK;
              addr_r     <= `CTW_SEG_BASE;
              mem_addr_o <= `CTW_SEG_BASE; // R1
            end
          end
        end
        ST_CHK: if (mem_ack_i) begin
          if (addr_r == `CTW_SEG_BASE)
            csum_r <= mem_data_i; // R1
          else
            xor_r <= xor_r ^ mem_data_i; // R2
          if (addr_r == `CTW_SEG_END - `CTW_WORD_STEP) begin
            // Sum of XOR and stored word must wrap to zero
            if ((xor_r ^ mem_data_i) + csum_r == 16'h0000) begin // R3
              seg_valid_o <= 1'b1;
              tag_addr_r  <= `CTW_FIRST_REC; // R4
              mem_addr_o  <= `CTW_FIRST_REC;
              mem_rd_o    <= 1'b1;
              state_r     <= ST_HDR;
            end else begin
              chk_err_o <= 1'b1; // R3
              state_r   <= ST_DONE;
            end
          end else begin
            addr_r     <= addr_r + `CTW_WORD_STEP;
            mem_addr_o <= addr_r + `CTW_WORD_STEP;
            mem_rd_o   <= 1'b1;
          end
        end
        ST_HDR: if (mem_ack_i) begin
          // Records start on even addresses: tag low, length high
          tag_r  <= mem_data_i[7:0];
          len_r  <= mem_data_i[15:8]; // R5
          voff_r <= 8'h00;
          if (mem_data_i[7:0] == `CTW_TAG_OSC) begin // R9
            osc_found_o <= 1'b1;
            mem_addr_o  <= val_addr(tag_addr_r, {4'h0, sel_rng_off & 4'hE}); // R12
            mem_rd_o    <= 1'b1;
            state_r     <= ST_VAL;
          end else if (mem_data_i[7:0] == `CTW_TAG_CONV) begin // R10
            conv_found_o <= 1'b1;
            mem_addr_o   <= val_addr(tag_addr_r, 8'h00);
            mem_rd_o     <= 1'b1;
            state_r      <= ST_VAL;
          end else begin
            state_r <= ST_NEXT; // R8 R11
          end
        end
        ST_VAL: if (mem_ack_i) begin
          if (tag_r == `CTW_TAG_OSC) begin
            range_byte_o <= pick_byte(mem_data_i, sel_rng_off[0]); // R12 R13
            step_byte_o  <= pick_byte(mem_data_i, ~sel_rng_off[0]); // R12 R13
            state_r      <= apply_en_i ? ST_AP0 : ST_NEXT;
          end else begin
            case (voff_r[4:0])
              `CTW_CNV_GAIN: gain_word_o <= mem_data_i; // R16
              `CTW_CNV_OFFS: offset_word_o <= mem_data_i; // R16
              `CTW_CNV_LREF: low_reference_scale_word_o <= mem_data_i; // R16
              `CTW_CNV_LT30: low_ref_temp30_result_o <= mem_data_i; // R17
              `CTW_CNV_LT85: low_ref_temp85_result_o <= mem_data_i; // R17
              `CTW_CNV_HREF: high_reference_scale_word_o <= mem_data_i; // R17
              `CTW_CNV_HT30: high_ref_temp30_result_o <= mem_data_i; // R17
              default:       high_ref_temp85_result_o <= mem_data_i; // R17
            endcase
            if (voff_r[4:0] == `CTW_CNV_HT85) begin
              state_r <= ST_NEXT;
            end else begin
              voff_r     <= voff_r + 8'h02;
              mem_addr_o <= val_addr(tag_addr_r, voff_r + 8'h02);
              mem_rd_o   <= 1'b1;
            end
          end
        end
        ST_NEXT: begin
          // Chain to the next record, stop once the next tag reaches the last segment byte 0x10FF
          if (next_tag >= `CTW_SEG_LAST) begin // R7
            state_r <= ST_DONE;
          end else begin
            tag_addr_r <= next_tag; // R6
            mem_addr_o <= next_tag;
            mem_rd_o   <= 1'b1;
            state_r    <= ST_HDR;
          end
        end
        ST_DIR: if (mem_ack_i) begin
          osc_found_o  <= 1'b1;
          range_byte_o <= pick_byte(mem_data_i, sel_rng_off[0]); // R15
          step_byte_o  <= pick_byte(mem_data_i, ~sel_rng_off[0]);
          state_r      <= apply_en_i ? ST_AP0 : ST_DONE;
        end
        ST_AP0: begin
          clk_wr_o        <= 1'b1; // R14
          clk_sel_range_o <= 1'b0;
          clk_wdata_o     <= 8'h00;
          state_r         <= ST_AP1;
        end
        ST_AP1: begin
          clk_wr_o        <= 1'b1; // R14
          clk_sel_range_o <= 1'b1;
          clk_wdata_o     <= range_byte_o;
          state_r         <= ST_AP2;
        end
        ST_AP2: begin
          clk_wr_o        <= 1'b1; // R14
          clk_sel_range_o <= 1'b0;
          clk_wdata_o     <= step_byte_o;
          state_r         <= direct_osc_i ? ST_DONE : ST_NEXT;
        end
        ST_DONE: begin
          busy_o  <= 1'b0;
          done_o  <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule // ctw_walker

/* File: testbench/ctw_walker_sva.sv */
`timescale 1ns/10ps
// --------
// Port checker for the segment walker
// --------
module ctw_walker_sva (
  // Clock, reset, control
  input logic        clock_i,
  input logic        sys_rst_i,
  input logic        start_i,
  input logic        direct_osc_i,
  // Flash read port
  input logic        mem_rd_o,
  input logic [15:0] mem_addr_o,
  // Clock writes and status
  input logic        clk_wr_o,
  input logic        clk_sel_range_o,
  input logic [7:0]  clk_wdata_o,
  input logic        busy_o,
  input logic        done_o,
  input logic        seg_valid_o,
  input logic        chk_err_o,
  input logic        conv_found_o,
  input logic [7:0]  range_byte_o,
  input logic [7:0]  step_byte_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // Apply steps: step cleared first so the range change never meets a high step
  sequence s_clear; clk_wr_o && !clk_sel_range_o && clk_wdata_o == 8'h00; endsequence
  sequence s_range; clk_wr_o && clk_sel_range_o && clk_wdata_o == range_byte_o; endsequence
  sequence s_step; clk_wr_o && !clk_sel_range_o && clk_wdata_o == step_byte_o; endsequence
  a_apply_write_order: assert property (clk_wr_o && !$past(clk_wr_o) |-> s_clear ##1 s_range ##1 s_step)
    else $error("clock writes out of order");
  a_walk_first_read: assert property (start_i && !busy_o && !done_o && !direct_osc_i |=>
    mem_rd_o && mem_addr_o == 16'h10C0)
    else $error("walk did not open at the checksum word");
  a_read_in_segment: assert property (mem_rd_o |-> !mem_addr_o[0] &&
    mem_addr_o >= 16'h10C0 && mem_addr_o <= 16'h10FE)
    else $error("read outside the segment");
  a_read_one_cycle: assert property (mem_rd_o |=> !mem_rd_o)
    else $error("read request longer than one cycle");
  a_valid_err_excl: assert property (!(seg_valid_o && chk_err_o))
    else $error("valid and error together");
  a_err_no_apply: assert property (chk_err_o |-> !clk_wr_o)
    else $error("clock write after checksum error");
  a_done_one_cycle: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_conv_needs_valid: assert property (conv_found_o |-> seg_valid_o)
    else $error("converter record taken from bad segment");
  a_done_ends_busy: assert property (done_o |-> !busy_o)
    else $error("done while still busy");
  a_first_tag_read: assert property ($rose(seg_valid_o) |-> mem_rd_o && mem_addr_o == 16'h10C2)
    else $error("record walk did not open at the first tag");
  a_direct_fixed_read: assert property (start_i && !busy_o && !done_o && direct_osc_i |=>
    mem_rd_o && mem_addr_o >= 16'h10F8 && mem_addr_o <= 16'h10FE)
    else $error("direct fetch outside the fixed block");
endmodule // ctw_walker_sva

bind ctw_walker ctw_walker_sva i_ctw_walker_sva (.clock_i, .sys_rst_i, .start_i, .direct_osc_i,
  .mem_rd_o, .mem_addr_o, .clk_wr_o, .clk_sel_range_o, .clk_wdata_o, .busy_o, .done_o,
  .seg_valid_o, .chk_err_o, .conv_found_o, .range_byte_o, .step_byte_o);

/* File: testbench/ctw_flash_model.sv */
`timescale 1ns/10ps
// --------
// Information memory: one word per read, wait_i extra cycles
// --------
module ctw_flash_model (
  // Clock and request
  input  logic        clock_i,
  input  logic        rd_i,
  input  logic [15:0] addr_i,
  input  logic [3:0]  wait_i,
  // Answer
  output logic        ack_o,
  output logic [15:0] data_o
);
  logic [15:0] mem [0:31];
  logic [15:0] addr_r;
  logic [3:0]  cnt_r;
  logic        pend_r = 1'b0;
  initial ack_o = 1'b0;
  initial data_o = 16'hA5A5;
  // Data toggles outside the ack cycle so a stale word is never reused
  always @(posedge clock_i) begin
    ack_o <= 1'b0;
    data_o <= ~data_o;
    if (rd_i) begin
      pend_r <= 1'b1;
      cnt_r <= wait_i;
      addr_r <= addr_i;
    end else if (pend_r && cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else if (pend_r) begin
      pend_r <= 1'b0;
      ack_o <= 1'b1;
      data_o <= mem[addr_r[5:1]];
    end
  end
endmodule // ctw_flash_model

/* File: testbench/ctw_walker_tb_top.sv */
`timescale 1ns/10ps
`include "ctw_defs.vh"
module ctw_walker_tb_top;
  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        start_i = 1'b0;
  logic [1:0]  freq_sel_i = 2'h0;
  logic        apply_en_i = 1'b0;
  logic        direct_osc_i = 1'b0;
  logic [3:0]  wait_v = 4'h0;
  wire         mem_rd_o, mem_ack_i, clk_wr_o, clk_sel_range_o, busy_o, done_o;
  wire         seg_valid_o, chk_err_o, osc_found_o, conv_found_o;
  wire  [15:0] mem_addr_o, mem_data_i;
  wire  [7:0]  clk_wdata_o, range_byte_o, step_byte_o;
  wire  [15:0] cw [0:7];
  logic [7:0]  img [0:63];
  logic [8:0]  wq [$];
  int          err_total = 0;
  int          checked = 0;
  always #4 clock_i = ~clock_i;
  ctw_walker i_ctw_walker (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .start_i(start_i),
    .freq_sel_i(freq_sel_i), .apply_en_i(apply_en_i), .direct_osc_i(direct_osc_i),
    .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i),
    .mem_data_i(mem_data_i), .clk_wr_o(clk_wr_o), .clk_sel_range_o(clk_sel_range_o),
    .clk_wdata_o(clk_wdata_o), .busy_o(busy_o), .done_o(done_o), .seg_valid_o(seg_valid_o),
    .chk_err_o(chk_err_o), .osc_found_o(osc_found_o), .conv_found_o(conv_found_o),
    .range_byte_o(range_byte_o), .step_byte_o(step_byte_o),
    .gain_word_o(cw[0]), .offset_word_o(cw[1]),
    .low_reference_scale_word_o(cw[2]), .low_ref_temp30_result_o(cw[3]),
    .low_ref_temp85_result_o(cw[4]), .high_reference_scale_word_o(cw[5]),
    .high_ref_temp30_result_o(cw[6]), .high_ref_temp85_result_o(cw[7]));
  ctw_flash_model i_ctw_flash_model (.clock_i, .rd_i(mem_rd_o), .addr_i(mem_addr_o),
    .wait_i(wait_v), .ack_o(mem_ack_i), .data_o(mem_data_i));
  // Log clock writes as {range select, data}
  always @(posedge clock_i) if (clk_wr_o) wq.push_back({clk_sel_range_o, clk_wdata_o});
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Image: tag0 record, converter, filler, oscillator; bad adds one to the sum
  task automatic load(input logic [7:0] tag0, input logic bad);
    logic [15:0] x;
    x = 16'h0000;
    for (int i = 0; i < 64; i++) img[i] = 8'(i * 7 + 33);
    {img[3], img[2]} = {8'h16, tag0};
    {img[27], img[26]} = {8'h10, `CTW_TAG_CONV};
    {img[45], img[44]} = {8'h08, `CTW_TAG_EMPTY};
    {img[55], img[54]} = {8'h08, `CTW_TAG_OSC};
    for (int k = 1; k < 32; k++) x = x ^ {img[2*k+1], img[2*k]};
    {img[1], img[0]} = -x + 16'(bad);
    for (int k = 0; k < 32; k++) i_ctw_flash_model.mem[k] = {img[2*k+1], img[2*k]};
  endtask
  // One pulse of start, then a bounded wait for done
  task automatic run(input logic [1:0] fs, input logic ap, input logic dir);
    int n;
    n = 0;
    wq.delete();
    @(negedge clock_i);
    {freq_sel_i, apply_en_i, direct_osc_i, start_i} = {fs, ap, dir, 1'b1};
    @(negedge clock_i);
    start_i = 1'b0;
    while (done_o !== 1'b1 && n < 2000) begin
      @(negedge clock_i);
      n++;
    end
    if (done_o !== 1'b1) begin
      err_total++;
      results();
    end
    chk(16'(busy_o), 16'h0000);
    repeat (4) @(negedge clock_i);
  endtask
  task automatic applied(input logic [1:0] fs, input logic ap);
    logic [7:0] r;
    logic [7:0] s;
    r = img[63 - 2*fs];
    s = img[62 - 2*fs];
    chk(16'(range_byte_o), 16'(r));
    chk(16'(step_byte_o), 16'(s));
    chk(16'(wq.size()), ap ? 16'h0003 : 16'h0000);
    if (ap) begin
      chk(16'(wq[0]), 16'h0000);
      chk(16'(wq[1]), {7'h00, 1'b1, r});
      chk(16'(wq[2]), {7'h00, 1'b0, s});
    end
  endtask
  task automatic walk(input logic [1:0] fs, input logic [7:0] tag0, input logic bad,
                      input logic ap);
    load(tag0, bad);
    run(fs, ap, 1'b0);
    chk(16'(chk_err_o), 16'(bad));
    chk(16'(seg_valid_o), 16'(!bad));
    chk(16'(conv_found_o), 16'(!bad));
    chk(16'(osc_found_o), 16'(!bad));
    if (!bad) begin
      for (int j = 0; j < 8; j++) chk(cw[j], {img[29+2*j], img[28+2*j]});
      applied(fs, ap);
    end else
      chk(16'(wq.size()), 16'h0000);
    $display("walk fs=%0d tag=%h bad=%0d done", fs, tag0, bad);
  endtask
  // Fixed-address fetch on a bad segment; the chosen pair is inverted so stale bytes show
  task automatic direct(input logic [1:0] fs);
    load(`CTW_TAG_EMPTY, 1'b1);
    {img[63-2*fs], img[62-2*fs]} = ~{img[63-2*fs], img[62-2*fs]};
    i_ctw_flash_model.mem[31-fs] = {img[63-2*fs], img[62-2*fs]};
    run(fs, 1'b1, 1'b1);
    chk(16'(seg_valid_o), 16'h0000);
    chk(16'(osc_found_o), 16'h0001);
    chk(16'(conv_found_o), 16'h0000);
    applied(fs, 1'b1);
    $display("direct fs=%0d done", fs);
  endtask
  initial begin
    repeat (5) @(posedge clock_i);
    @(negedge clock_i);
    sys_rst_i = 1'b0;
    walk(2'h0, `CTW_TAG_EMPTY, 1'b0, 1'b1);
    wait_v = 4'h3;
    walk(2'h1, `CTW_TAG_EMPTY, 1'b0, 1'b1);
    walk(2'h2, 8'h33, 1'b0, 1'b1);
    wait_v = 4'h0;
    walk(2'h3, `CTW_TAG_EMPTY, 1'b0, 1'b0);
    walk(2'h0, `CTW_TAG_EMPTY, 1'b1, 1'b1);
    direct(2'h3);
    direct(2'h0);
    results();
  end
endmodule // ctw_walker_tb_top
